// File: verilog/sfcr_pkg.sv
// Shared constants and types of the serial peripheral port
package sfcr_pkg;
  // ==========================================
  // Register addresses
  localparam logic [7:0] ADDR_CTRL = 8'hf8;
  localparam logic [7:0] ADDR_CFG = 8'ha1;
  localparam logic [7:0] ADDR_CKR = 8'ha2;
  localparam logic [7:0] ADDR_DAT = 8'ha3;
  // ==========================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h06;
  localparam logic [7:0] CKR_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'h00;
  // ==========================================
  // Control register fields
  localparam int CN_DONE = 7;
  localparam int CN_WRITE_COLLISION_FLAG = 6;
  localparam int CN_MODE_FAULT_FLAG = 5;
  localparam int CN_OVR = 4;
  localparam int CN_MODE_HI = 3;
  localparam int CN_MODE_LO = 2;
  localparam int CN_TXE = 1;
  localparam int CN_EN = 0;
  // Flag vector order inside the block: done, collision, fault, overrun
  localparam int FL_DONE = 3;
  localparam int FL_WRITE_COLLISION_FLAG = 2;
  localparam int FL_MODE_FAULT_FLAG = 1;
  localparam int FL_OVR = 0;
  // ==========================================
  // Config register fields
  localparam int CF_MST = 6;
  localparam int CF_PHA = 5;
  localparam int CF_POL = 4;
  // ==========================================
  // Timing
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int MAX_MASTER_BPS = 12_500_000;
  localparam logic [3:0] LAST_HALF = 4'hf;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // ==========================================
  // Enumerations
  typedef enum logic [1:0] {
    SEL_3W = 2'b00,
    SEL_4W_IN = 2'b01,
    SEL_OUT_LO = 2'b10,
    SEL_OUT_HI = 2'b11
  } sfcr_selmode_t;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_SHIFT = 2'b01
  } sfcr_mstate_t;
endpackage

// File: verilog/sfcr_byte_if.sv
// Byte stream carrier with valid and ready
`timescale 1ns/100ps
interface sfcr_byte_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: verilog/sfcr_buf.sv
// Small first-in first-out buffer for received bytes
`timescale 1ns/100ps
module sfcr_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  sfcr_byte_if.snk wr,
  sfcr_byte_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  // ==========================================
  // Parameter check
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("Buffer depth must be a power of two of at least two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } sfcr_buf_t;
  sfcr_buf_t s_r;
  sfcr_buf_t s_nxt;
  logic push;
  logic pop;
  // ==========================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    push = wr.valid && (s_r.cnt != CW'(DEPTH));
    pop = rd.ready && (s_r.cnt != '0);
    if (push) begin
      s_nxt.mem[s_r.wp] = wr.data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // Full stalls the source instead of dropping
  assign wr.ready = (s_r.cnt != CW'(DEPTH));
  assign rd.valid = (s_r.cnt != '0);
  assign rd.data = s_r.mem[s_r.rp];
  // ==========================================
  // Checks
  a_buf_count_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_r.cnt <= CW'(DEPTH))
    else $error("Buffer count above depth");
endmodule

// File: verilog/sfcr_deglitch.sv
// Two-sample filter for the slave select input
`timescale 1ns/100ps
module sfcr_deglitch (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic filt
);
  typedef struct packed {
    logic smp;
    logic filt;
  } sfcr_dg_t;
  sfcr_dg_t s_r;
  sfcr_dg_t s_nxt;
  // ==========================================
  // Filter
  // Level passes only after two equal samples, a one-cycle spike is dropped
  always_comb begin
    s_nxt = s_r;
    s_nxt.smp = pin;
    if (pin == s_r.smp) begin
      s_nxt.filt = pin;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= 2'b11;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign filt = s_r.filt;
endmodule

// File: verilog/sfcr_port.sv
// Serial peripheral port: flags, clocking, registers and shifter
//
// Function
// (R1) Set transfer-done flag at the end of every byte, every mode.
// (R2) With interrupt enabled, any of the four set flags requests an interrupt.
// (R3) Flags are never cleared by hardware; software clears each one.
// (R4) Data write with transmit buffer full sets collision flag and is dropped.
// (R5) Master in select mode 01 with select low: fault flag, clear master and enable.
// (R6) Slave completes while receive buffer full: overrun flag, new byte dropped.
// (R7) Phase bit 0 centres data on first clock edge, 1 on second.
// (R8) Polarity bit gives clock idle level: 0 low, 1 high.
// (R9) Disable before changing phase or polarity; both ends use same settings.
// (R10) Master bit rate at most half the core clock and 12.5 MHz.
// (R11) Remote master full duplex stays at or below a tenth of core clock.
// (R12) Remote master sending only, synchronous, may reach a quarter of core clock.
// (R13) Busy bit reads 1 while a byte is in progress.
// (R14) Master-enable bit: 0 slave, 1 master.
// (R15) Selected bit reads 1 when the filtered select input is low.
// (R16) Raw select bit returns the pin level at the read.
// (R17) Shift-empty bit: 1 when idle, cleared on load or clock toggle, 1 as master.
// (R18) Receive-empty bit: 1 when nothing unread, 1 as master.
// (R19) Slave samples input mid-bit; master samples one core clock before bit end.
// (R20) Select mode 00 no pin, 01 input, 1x output equal to low bit.
// (R21) Transmit-empty clears on data write, sets when moved to shifter.
// (R22) Block-enable bit switches the whole port on or off.
// (R23) Master clock rate is core clock over twice divider plus one.
// (R24) Master write with shifter empty loads it and starts at once; here the start also waits until the receive buffer has room.
// (R25) Falling select resets bit counter; remote selects two clocks before edge.
// (R26) Bytes shift in most significant bit first; eight bits go to buffer.
// (R27) On mode fault stop driving clock and data at once, abandon byte.
// (R28) Writing 1 to a flag leaves it; writing 0 clears it.
`timescale 1ns/100ps
module sfcr_port #(
  parameter int SYS_CLK_HZ = sfcr_pkg::SYS_CLK_HZ,
  parameter int RX_DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic irq_en,
  output logic irq_req,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic nss_in,
  output logic nss_out,
  output logic nss_oe_n
);
  // ==========================================
  // Clock rate limits
  // Least half period rounds up so the rate never passes the limit
  localparam int MIN_HALF = (SYS_CLK_HZ + 2 * sfcr_pkg::MAX_MASTER_BPS - 1)
    / (2 * sfcr_pkg::MAX_MASTER_BPS);
  localparam logic [7:0] MIN_DIV = 8'(MIN_HALF - 1);
  if (MIN_HALF < 1 || MIN_HALF > 256 || RX_DEPTH < 2) begin : g_chk
    $error("Clock rate or buffer depth out of range");
  end

  function automatic logic [7:0] half_reload(input logic [7:0] ckr);
    return (ckr < MIN_DIV) ? MIN_DIV : ckr; // R10 R23
  endfunction

  typedef struct packed {
    logic [3:0] flags;
    sfcr_pkg::sfcr_selmode_t mode;
    logic en;
    logic mst;
    logic pha;
    logic pol;
    logic [7:0] ckr;
    logic [7:0] txb;
    logic txe;
    logic shift_reg_empty;
    sfcr_pkg::sfcr_mstate_t mst_st;
    logic [3:0] half;
    logic [7:0] div;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic [3:0] cnt;
    logic busy;
    logic sck_q;
    logic nss_q;
    logic sck_o;
    logic sck_oe_n;
    logic mosi_o;
    logic mosi_oe_n;
    logic miso_o;
    logic miso_oe_n;
    logic nss_o;
    logic nss_oe_n;
    logic [7:0] rdata;
    logic irq;
  } sfcr_state_t;

  sfcr_state_t s_r;
  sfcr_state_t s_nxt;
  logic nss_filt;
  logic [3:0] set_fl;
  logic [3:0] clr_vec;
  logic sck_edge;
  logic lead;
  logic trail;
  logic slave_act;
  logic sample;
  logic shift;
  logic sl_done;
  logic [7:0] rx_byte;
  logic push_v;
  logic pop;
  logic wr_ctrl;
  logic wr_dat;

  sfcr_byte_if #(.WIDTH(8)) rx_wr ();
  sfcr_byte_if #(.WIDTH(8)) rx_rd ();

  sfcr_buf #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rxbuf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr(rx_wr.snk),
    .rd(rx_rd.src)
  );

  sfcr_deglitch u_sel (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin(nss_in),
    .filt(nss_filt)
  );

  assign rx_wr.valid = push_v;
  assign rx_wr.data = rx_byte;
  assign rx_rd.ready = pop;

  // ==========================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    set_fl = 4'h0;
    push_v = 1'b0;
    rx_byte = s_r.rxsh;
    sl_done = 1'b0;
    wr_ctrl = sfr_wr && (sfr_addr == sfcr_pkg::ADDR_CTRL);
    wr_dat = sfr_wr && (sfr_addr == sfcr_pkg::ADDR_DAT);
    pop = sfr_rd && (sfr_addr == sfcr_pkg::ADDR_DAT);
    clr_vec = wr_ctrl ? ~sfr_wdata[7:4] : 4'h0;
    s_nxt.sck_q = sck_in;
    s_nxt.nss_q = nss_filt;
    sck_edge = (sck_in != s_r.sck_q);
    lead = sck_edge && (sck_in != s_r.pol);
    trail = sck_edge && (sck_in == s_r.pol);
    slave_act = s_r.en && !s_r.mst && ((s_r.mode == sfcr_pkg::SEL_3W)
      || (s_r.mode == sfcr_pkg::SEL_4W_IN && !nss_filt));
    sample = slave_act && (s_r.pha ? trail : lead); // R7 R19
    shift = slave_act && (s_r.pha ? lead : trail); // R7

    // Software writes first so hardware sets below win
    if (wr_ctrl) begin
      s_nxt.flags = s_r.flags & sfr_wdata[7:4]; // R3 R28
      s_nxt.mode = sfcr_pkg::sfcr_selmode_t'(sfr_wdata[3:2]);
      s_nxt.en = sfr_wdata[sfcr_pkg::CN_EN]; // R22
    end
    if (sfr_wr && sfr_addr == sfcr_pkg::ADDR_CFG) begin
      s_nxt.mst = sfr_wdata[sfcr_pkg::CF_MST]; // R14
      // Taken even while enabled; software is to disable first
      s_nxt.pha = sfr_wdata[sfcr_pkg::CF_PHA]; // R9
      s_nxt.pol = sfr_wdata[sfcr_pkg::CF_POL]; // R9
    end
    if (sfr_wr && sfr_addr == sfcr_pkg::ADDR_CKR) begin
      s_nxt.ckr = sfr_wdata;
    end
    if (wr_dat) begin
      if (!s_r.txe) begin
        set_fl[sfcr_pkg::FL_WRITE_COLLISION_FLAG] = 1'b1; // R4
      end else begin
        s_nxt.txb = sfr_wdata;
        s_nxt.txe = 1'b0; // R21
      end
    end

    // Master shifter
    case (s_r.mst_st)
      sfcr_pkg::M_IDLE: begin
        // Full receive buffer holds off the next byte
        if (s_r.en && s_r.mst && !s_r.txe && rx_wr.ready) begin
          s_nxt.txsh = s_r.txb; // R24
          s_nxt.txe = 1'b1; // R21
          s_nxt.half = 4'h0;
          s_nxt.div = half_reload(s_r.ckr);
          s_nxt.mst_st = sfcr_pkg::M_SHIFT;
          s_nxt.busy = 1'b1; // R13
        end
      end
      sfcr_pkg::M_SHIFT: begin
        if (s_r.div != 8'h00) begin
          s_nxt.div = s_r.div - 8'h01;
          if (s_r.half[0] && s_r.div == 8'h01) begin
            s_nxt.rxsh = {s_r.rxsh[6:0], miso_in}; // R19 R26
          end
        end else begin
          s_nxt.div = half_reload(s_r.ckr); // R23
          s_nxt.half = s_r.half + 4'h1;
          if (s_r.half[0]) begin
            s_nxt.txsh = {s_r.txsh[6:0], 1'b0};
          end
          if (s_r.half == sfcr_pkg::LAST_HALF) begin
            set_fl[sfcr_pkg::FL_DONE] = 1'b1; // R1
            push_v = 1'b1; // R26
            s_nxt.mst_st = sfcr_pkg::M_IDLE;
            s_nxt.busy = 1'b0; // R13
          end
        end
      end
      default: begin
        s_nxt.mst_st = sfcr_pkg::M_IDLE;
      end
    endcase

    // Slave shifter
    if (!s_r.mst && s_r.shift_reg_empty && !s_r.txe) begin
      s_nxt.txsh = s_r.txb;
      s_nxt.txe = 1'b1; // R21
      s_nxt.shift_reg_empty = 1'b0; // R17
    end
    if (slave_act && sck_edge) begin
      s_nxt.shift_reg_empty = 1'b0; // R17
    end
    // Phase 0 trailing edge after the last sample starts no byte
    if (sample || (shift && s_r.pha)) begin
      s_nxt.busy = 1'b1; // R13
    end
    if (shift && s_r.cnt != 4'h0) begin
      s_nxt.txsh = {s_r.txsh[6:0], 1'b0};
    end
    if (sample) begin
      s_nxt.rxsh = {s_r.rxsh[6:0], mosi_in}; // R26
      s_nxt.cnt = s_r.cnt + 4'h1;
      if (s_r.cnt == sfcr_pkg::LAST_BIT) begin
        sl_done = 1'b1;
        s_nxt.cnt = 4'h0;
        s_nxt.busy = 1'b0; // R13
        set_fl[sfcr_pkg::FL_DONE] = 1'b1; // R1
        rx_byte = {s_r.rxsh[6:0], mosi_in};
        push_v = rx_wr.ready;
        set_fl[sfcr_pkg::FL_OVR] = !rx_wr.ready; // R6
        if (!s_r.txe) begin
          s_nxt.txsh = s_r.txb;
          s_nxt.txe = 1'b1; // R21
        end else begin
          s_nxt.shift_reg_empty = 1'b1; // R17
        end
      end
    end
    // Only the select edge or a disable restarts a byte in slave mode
    if ((s_r.nss_q && !nss_filt && s_r.mode == sfcr_pkg::SEL_4W_IN) || !s_r.en) begin
      s_nxt.cnt = 4'h0; // R25
    end
    if (!s_r.en) begin
      s_nxt.mst_st = sfcr_pkg::M_IDLE; // R22
      s_nxt.busy = 1'b0;
    end

    // Mode fault overrides the master, enable, shifter state, busy, push and done set above
    if (s_r.en && s_r.mst && s_r.mode == sfcr_pkg::SEL_4W_IN && !nss_filt) begin
      set_fl[sfcr_pkg::FL_MODE_FAULT_FLAG] = 1'b1; // R5
      s_nxt.mst = 1'b0; // R5
      s_nxt.en = 1'b0; // R5
      s_nxt.mst_st = sfcr_pkg::M_IDLE; // R27
      s_nxt.busy = 1'b0;
      push_v = 1'b0;
      set_fl[sfcr_pkg::FL_DONE] = 1'b0;
    end
    s_nxt.flags = s_nxt.flags | set_fl; // R3

    // Pins follow the next state so a fault releases them at once
    s_nxt.sck_oe_n = !(s_nxt.en && s_nxt.mst); // R27
    s_nxt.mosi_oe_n = !(s_nxt.en && s_nxt.mst); // R27
    s_nxt.sck_o = (s_nxt.mst_st == sfcr_pkg::M_SHIFT) ?
      (s_r.pol ^ s_r.pha ^ s_nxt.half[0]) : s_r.pol; // R7 R8
    s_nxt.mosi_o = s_nxt.txsh[7];
    s_nxt.miso_oe_n = !(s_nxt.en && !s_nxt.mst && ((s_nxt.mode == sfcr_pkg::SEL_3W)
      || (s_nxt.mode == sfcr_pkg::SEL_4W_IN && !nss_filt)));
    s_nxt.miso_o = s_nxt.txsh[7];
    s_nxt.nss_oe_n = !(s_nxt.en && s_nxt.mode[1]); // R20
    s_nxt.nss_o = s_nxt.mode[0]; // R20
    s_nxt.irq = irq_en && (s_nxt.flags != 4'h0); // R2

    // Register read
    if (sfr_rd) begin
      if (sfr_addr == sfcr_pkg::ADDR_CTRL) begin
        s_nxt.rdata = {s_r.flags, s_r.mode, s_r.txe, s_r.en};
      end else if (sfr_addr == sfcr_pkg::ADDR_CFG) begin
        s_nxt.rdata = {s_r.busy, s_r.mst, s_r.pha, s_r.pol, !nss_filt, nss_in,
          s_r.mst | s_r.shift_reg_empty, s_r.mst | !rx_rd.valid}; // R13 R15 R16 R17 R18
      end else if (sfr_addr == sfcr_pkg::ADDR_CKR) begin
        s_nxt.rdata = s_r.ckr;
      end else if (sfr_addr == sfcr_pkg::ADDR_DAT) begin
        s_nxt.rdata = rx_rd.valid ? rx_rd.data : sfcr_pkg::DAT_RST;
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.flags <= sfcr_pkg::CTRL_RST[7:4];
      s_r.mode <= sfcr_pkg::sfcr_selmode_t'(sfcr_pkg::CTRL_RST[3:2]);
      s_r.txe <= sfcr_pkg::CTRL_RST[sfcr_pkg::CN_TXE];
      s_r.en <= sfcr_pkg::CTRL_RST[sfcr_pkg::CN_EN];
      s_r.ckr <= sfcr_pkg::CKR_RST;
      s_r.shift_reg_empty <= 1'b1;
      s_r.sck_q <= 1'b0;
      s_r.nss_q <= 1'b1;
      s_r.sck_oe_n <= 1'b1;
      s_r.mosi_oe_n <= 1'b1;
      s_r.miso_oe_n <= 1'b1;
      s_r.nss_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata = s_r.rdata;
  assign irq_req = s_r.irq;
  assign sck_out = s_r.sck_o;
  assign sck_oe_n = s_r.sck_oe_n;
  assign mosi_out = s_r.mosi_o;
  assign mosi_oe_n = s_r.mosi_oe_n;
  assign miso_out = s_r.miso_o;
  assign miso_oe_n = s_r.miso_oe_n;
  assign nss_out = s_r.nss_o;
  assign nss_oe_n = s_r.nss_oe_n;

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence q_last_half;
    s_r.mst_st == sfcr_pkg::M_SHIFT && s_r.half == sfcr_pkg::LAST_HALF && s_r.div == 8'h00;
  endsequence
  sequence q_fault;
    s_r.en && s_r.mst && s_r.mode == sfcr_pkg::SEL_4W_IN && !nss_filt;
  endsequence
  sequence q_no_fault;
    !(s_r.en && s_r.mst && s_r.mode == sfcr_pkg::SEL_4W_IN && !nss_filt);
  endsequence
  sequence q_start;
    s_r.mst_st == sfcr_pkg::M_IDLE && s_r.en && s_r.mst && !s_r.txe && rx_wr.ready;
  endsequence

  a_done_master: assert property ( // R1
    q_last_half ##0 q_no_fault |=> s_r.flags[sfcr_pkg::FL_DONE])
    else $error("Done flag missing after master byte");
  a_flag_sticky: assert property ( // R3
    1'b1 |=> (($past(s_r.flags) & ~$past(clr_vec) & ~s_r.flags) == 4'h0))
    else $error("Flag cleared without software write of zero");
  a_write_collision_flag_drop: assert property ( // R4
    wr_dat && !s_r.txe |=> s_r.flags[sfcr_pkg::FL_WRITE_COLLISION_FLAG] && $stable(s_r.txb))
    else $error("Collision write not dropped");
  a_fault_stop: assert property ( // R5
    q_fault |=> s_r.flags[sfcr_pkg::FL_MODE_FAULT_FLAG] && !s_r.en && !s_r.mst && sck_oe_n && mosi_oe_n)
    else $error("Mode fault not handled");
  a_ovr_set: assert property ( // R6
    sl_done && !rx_wr.ready |=> s_r.flags[sfcr_pkg::FL_OVR])
    else $error("Overrun flag missing");
  a_sck_idle: assert property ( // R8
    s_r.mst_st == sfcr_pkg::M_IDLE |=> s_r.mst_st != sfcr_pkg::M_IDLE || sck_out == $past(s_r.pol))
    else $error("Clock not at idle level");
  a_half_min: assert property ( // R10
    s_r.mst_st == sfcr_pkg::M_SHIFT && $changed(sck_out) |=> $stable(sck_out) || !s_r.en)
    else $error("Master clock half period below limit");
  a_start_now: assert property ( // R24
    q_start ##0 q_no_fault |=> s_r.mst_st == sfcr_pkg::M_SHIFT && s_r.txe && s_r.busy ##1
      $stable(s_r.txsh))
    else $error("Master byte did not start");
  a_sel_out: assert property ( // R20
    s_r.en && s_r.mode[1] |-> !nss_oe_n && nss_out == s_r.mode[0])
    else $error("Select output wrong");
  a_irq_flag: assert property ( // R2
    irq_en && (s_nxt.flags != 4'h0) |=> irq_req)
    else $error("Interrupt not raised");
endmodule

// File: tb/sfcr_remote_slave.sv
// Behavioural remote slave on the far side of the serial port
`timescale 1ns/100ps
module sfcr_remote_slave (
  input wire logic sck,
  input wire logic mosi,
  input wire logic active,
  input wire logic pol,
  input wire logic pha,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  // ==========================================
  // Shifter
  int cnt = 0;
  logic bit_v;
  initial rx_byte = 8'h00;
  always @(posedge active) cnt = 0;
  always @(sck) begin
    if (active) begin
      // Same phase and polarity as the port, or bits land shifted
      if ((sck != pol) == !pha) begin
        rx_byte = {rx_byte[6:0], mosi};
      end else begin
        cnt = cnt + 1;
      end
    end
  end
  always_comb begin
    bit_v = pha ? tx_byte[(8 - cnt) & 7] : tx_byte[(7 - cnt) & 7];
    // Released line shows the inverse so a stale level never passes
    miso = active ? bit_v : ~bit_v;
  end
endmodule

// File: tb/sfcr_port_tb.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/100ps
module sfcr_port_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rb, rem_tx = 8'h00, rem_rx, mo;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, irq_en = 1'b1, irq_req, rem_miso;
  logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, nss_out, nss_oe_n;
  logic m_sck = 1'b0, m_mosi = 1'b0, slave_select_line = 1'b1, act = 1'b0, pol = 1'b0, pha = 1'b0;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  wire sck_w = sck_oe_n ? m_sck : sck_out;
  wire mosi_w = mosi_oe_n ? m_mosi : mosi_out;
  wire miso_w = miso_oe_n ? rem_miso : miso_out;

  sfcr_port i_sfcr_port (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .irq_en(irq_en), .irq_req(irq_req), .sck_in(sck_w), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .nss_in(slave_select_line),
    .nss_out(nss_out), .nss_oe_n(nss_oe_n));
  sfcr_remote_slave i_sfcr_remote_slave (.sck(sck_w), .mosi(mosi_w), .active(act),
    .pol(pol), .pha(pha), .tx_byte(rem_tx), .miso(rem_miso), .rx_byte(rem_rx));

  // ==========================================
  // Clock and hang guard
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // ==========================================
  // Register access and compare tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    @(posedge sys_clk);
    d = sfr_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    rd(a, rb);
    chk(n, e, rb);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    rb = 8'h00;
    while (rb[7] !== 1'b1 && k < 300) begin
      rd(8'hf8, rb);
      k++;
    end
    chk("done flag", 8'h01, {7'h00, rb[7]});
  endtask
  task automatic finish_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // Master byte with remote slave, one phase and polarity
  task automatic mst(input logic pl, input logic ph, input logic [7:0] dv,
                     input logic [7:0] d, input logic [7:0] r);
    int t;
    t = 0;
    wr(8'hf8, 8'h00);
    pol = pl;
    pha = ph;
    wr(8'ha1, {2'b01, ph, pl, 4'h0});
    wr(8'ha2, dv);
    wr(8'hf8, 8'h01);
    // Clock pin settles to idle before the remote model arms
    @(posedge sys_clk);
    rem_tx = r;
    act = 1'b1;
    wr(8'ha3, d);
    while (sck_out === pl && t < 100) begin
      @(posedge sys_clk);
      t++;
    end
    t = 0;
    while (sck_out !== pl && t < 100) begin
      @(posedge sys_clk);
      t++;
    end
    chk("half period", dv + 8'h01, t[7:0]);
    wait_done();
    chk("sck idle", {7'h00, pl}, {7'h00, sck_out});
    chk("irq", 8'h01, {7'h00, irq_req});
    rchk("cfg master", 8'ha1, {2'b01, ph, pl, 4'h7});
    rchk("rx byte", 8'ha3, r);
    chk("remote rx", d, rem_rx);
    act = 1'b0;
    wr(8'hf8, 8'h81);
    rchk("flag kept", 8'hf8, 8'h83);
    wr(8'hf8, 8'h01);
    rchk("flag cleared", 8'hf8, 8'h03);
  endtask

  // ==========================================
  // Bench acting as remote master, phase 0 polarity 0
  task automatic slv(input logic [7:0] d);
    mo = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      @(posedge sys_clk);
      m_mosi <= d[i];
      repeat (6) @(posedge sys_clk);
      m_sck <= 1'b1;
      mo[i] = miso_w;
      repeat (6) @(posedge sys_clk);
      m_sck <= 1'b0;
      if (i == 4) begin
        rd(8'ha1, rb);
        chk("busy", 8'h80, rb & 8'h80);
      end
    end
    repeat (4) @(posedge sys_clk);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk("ctrl reset", 8'hf8, 8'h06);
    rchk("cfg reset", 8'ha1, 8'h07);
    rchk("divider reset", 8'ha2, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    for (int i = 0; i < 4; i++) begin
      mst(i[0], i[1], 8'(i + 1), 8'ha5 ^ 8'(i), 8'h3c + 8'(i));
    end
    // Back-to-back data writes: second lands on a full transmit buffer
    act = 1'b1;
    @(posedge sys_clk);
    sfr_addr <= 8'ha3;
    sfr_wdata <= 8'h5a;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wdata <= 8'hc3;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    wait_done();
    chk("first write kept", 8'h5a, rem_rx);
    rchk("collision", 8'hf8, 8'hc3);
    rchk("rx collision", 8'ha3, 8'h3f);
    wr(8'hf8, 8'h05);
    // Select pulled low in mid-byte while multi-master
    wr(8'ha3, 8'h77);
    repeat (6) @(posedge sys_clk);
    slave_select_line <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("sck released", 8'h01, {7'h00, sck_oe_n});
    chk("mosi released", 8'h01, {7'h00, mosi_oe_n});
    chk("fault irq", 8'h01, {7'h00, irq_req});
    rchk("mode fault", 8'hf8, 8'h26);
    rd(8'ha1, rb);
    chk("master off", 8'h00, rb & 8'hc0);
    act = 1'b0;
    // Slave, four-wire: fresh select edge resets the bit count
    wr(8'ha1, 8'h00);
    wr(8'hf8, 8'h05);
    slave_select_line <= 1'b1;
    repeat (4) @(posedge sys_clk);
    slave_select_line <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rchk("cfg slave", 8'ha1, 8'h0b);
    wr(8'ha3, 8'h96);
    rd(8'ha1, rb);
    chk("shift loaded", 8'h00, rb & 8'h02);
    slv(8'h4e);
    chk("slave tx", 8'h96, mo);
    rchk("slave done", 8'hf8, 8'h87);
    rd(8'ha1, rb);
    chk("rx waiting", 8'h00, rb & 8'h01);
    chk("idle busy", 8'h00, rb & 8'h80);
    wr(8'hf8, 8'h05);
    slv(8'h11);
    slv(8'h22);
    rchk("overrun", 8'hf8, 8'h97);
    rchk("old byte 1", 8'ha3, 8'h4e);
    rchk("old byte 2", 8'ha3, 8'h11);
    rd(8'ha1, rb);
    chk("rx drained", 8'h01, rb & 8'h01);
    // Select driven as output follows the low mode bit
    wr(8'hf8, 8'h0d);
    @(posedge sys_clk);
    chk("nss high", 8'h01, {7'h00, nss_out});
    chk("nss driven", 8'h00, {7'h00, nss_oe_n});
    wr(8'hf8, 8'h09);
    @(posedge sys_clk);
    chk("nss low", 8'h00, {7'h00, nss_out});
    finish_test();
  end
endmodule
